// ===== gpc_board.sv
// Board-side model of the port pins: drivers, pull-ups and outside sources
`timescale 1ns/100ps
`default_nettype none

module gpc_board #(
  parameter int W = 29
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] lvl
);
  // A floating line must not read as a steady value
  logic [W-1:0] float_q = '0;

  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  assign lvl = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | float_q));
endmodule : gpc_board
`default_nettype wire

// ===== gpc_pin_cell.sv
// Output driver control for one port pin
`timescale 1ns/100ps
`default_nettype none

module gpc_pin_cell (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic latch,
  input  wire logic drv_sel,
  input  wire logic pu_sel,
  input  wire logic pseudo_ok,
  input  wire logic input_only,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pu
);

  logic       latch_prev_q;
  logic [3:0] kick_q;
  logic       rise;
  logic       kick_on;

  assign rise    = latch & ~latch_prev_q;
  assign kick_on = rise | (kick_q != 4'h0);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latch_prev_q <= 1'b1;
      kick_q       <= 4'h0;
    end else begin
      latch_prev_q <= latch;
      if (pseudo_ok && !drv_sel && !input_only && rise) begin
        kick_q <= 4'(gpc_pkg::PSEUDO_HIGH_CYC - 4'h1); // RULE2
      end else if (kick_q != 4'h0) begin
        kick_q <= kick_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pad_out <= 1'b1;
      pad_oe  <= 1'b0;
    end else if (input_only) begin
      // Never drives, whatever software wrote
      pad_out <= 1'b1; // RULE10
      pad_oe  <= 1'b0; // RULE10
    end else if (drv_sel) begin
      pad_out <= latch; // RULE3
      pad_oe  <= 1'b1;  // RULE3
    end else if (!latch) begin
      pad_out <= 1'b0; // RULE15
      pad_oe  <= 1'b1; // RULE15
    end else if (pseudo_ok && kick_on) begin
      // Brief active high speeds the rising edge
      pad_out <= 1'b1; // RULE2
      pad_oe  <= 1'b1; // RULE2
    end else begin
      // Released: input mode or pure open-drain high
      pad_out <= 1'b1; // RULE1 RULE9
      pad_oe  <= 1'b0; // RULE1 RULE9
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pad_pu <= 1'b0;
    end else begin
      pad_pu <= pu_sel | input_only; // RULE7 RULE11
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_input_never_drives: assert property (input_only |=> !pad_oe && pad_pu) // RULE10
    else $error("input-only pin drove or lost pull-up");
  chk_push_pull_follow: assert property ((drv_sel && !input_only) |=>
      pad_oe && (pad_out == $past(latch))) // RULE3
    else $error("push-pull pin does not follow latch");
  chk_open_drain_low: assert property ((!drv_sel && !latch && !input_only) |=>
      pad_oe && !pad_out) // RULE15
    else $error("open-drain pin not pulled low");
  chk_pure_od_release: assert property ((!drv_sel && latch && !pseudo_ok && !input_only) |=>
      !pad_oe) // RULE9
    else $error("pure open-drain pin not released");
  chk_pseudo_kick_end: assert property ((!drv_sel && latch && pseudo_ok && !input_only)
      [*4] |=> !pad_oe) // RULE2
    else $error("pseudo-open-drain kick did not end");

endmodule : gpc_pin_cell

`default_nettype wire

// ===== gpc_pkg.sv
// Shared constants for the general-purpose port block
package gpc_pkg;

  localparam int NPORT = 4;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_PA_DATA   = 6'h05;
  localparam logic [5:0] IDX_PB_DATA   = 6'h06;
  localparam logic [5:0] IDX_PC_DATA   = 6'h07;
  localparam logic [5:0] IDX_PD_DATA   = 6'h11;
  localparam logic [5:0] IDX_DRV_BASE  = 6'h20;
  localparam logic [5:0] IDX_PU_BASE   = 6'h24;
  localparam logic [5:0] IDX_VIEW_BASE = 6'h28;
  localparam logic [5:0] IDX_SET_BASE  = 6'h2c;
  localparam logic [5:0] IDX_CLR_BASE  = 6'h30;

  localparam logic [5:0] DATA_IDX [NPORT] = '{6'h05, 6'h06, 6'h07, 6'h11};

  // Reset values and implemented bits per port (A, B, C, D)
  localparam logic [7:0] LATCH_RST [NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h1f};
  localparam logic [7:0] DRV_RST            = 8'h00;
  localparam logic [7:0] PU_RST             = 8'h00;
  localparam logic [7:0] OUT_MASK  [NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h1f};
  localparam logic [7:0] IN_MASK   [NPORT] = '{8'hff, 8'hff, 8'hff, 8'h1f};

  // Flattened pin vector: port p occupies bits p*8 +: 8
  localparam logic [31:0] PIN_MASK    = 32'h1fff_ffff;
  localparam logic [31:0] PSEUDO_MASK = 32'h0000_0007;
  localparam logic [31:0] INONLY_MASK = 32'h0000_0080;

  // Pseudo-open-drain active high kick on a rising latch
  localparam int CLK_PERIOD_NS  = 40;
  localparam int PSEUDO_HIGH_NS = 80;
  localparam logic [3:0] PSEUDO_HIGH_CYC =
    4'((PSEUDO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : gpc_pkg

// ===== gpc_port_ctrl.sv
// General-purpose port controller with APB register access
// Summary of operation
// RULE1: Drive select 0 with latch 1 leaves the pin as a Schmitt input.
// RULE2: Port A pins 0-2 become pseudo-open-drain when drive select is 0.
// RULE3: Drive select 1 gives push-pull output driving the latch value.
// RULE4: Read-modify-write reads of port data return the output latch.
// RULE5: Plain reads of port data return synchronised pin levels.
// RULE6: Bit-set, bit-clear and register-destination updates use the latch.
// RULE7: Every pin except port A pin 7 has its own software-controlled pull-up.
// RULE8: Other pins behave like port A 0-2 without pseudo-open-drain.
// RULE9: Those pins give pure open-drain when the driver is off.
// RULE10: Port A pin 7 is input only and never drives.
// RULE11: Port A pin 7 pull-up is always connected; pad_pu is 0 during reset and turns on at the first clock after.
// RULE12: Port A latch bits 6-0 written at its data index, reset 7f.
// RULE13: Port B latch written at its data index, reset ff.
// RULE14: Port C latch written at its data index, reset ff.
// RULE15: Open-drain drives low on latch 0 and releases on latch 1.
`timescale 1ns/100ps
`default_nettype none

module gpc_port_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  output logic      [7:0]  pa_pu,
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe,
  output logic      [7:0]  pb_pu,
  input  wire logic [7:0]  pc_in,
  output logic      [7:0]  pc_out,
  output logic      [7:0]  pc_oe,
  output logic      [7:0]  pc_pu,
  input  wire logic [4:0]  pd_in,
  output logic      [4:0]  pd_out,
  output logic      [4:0]  pd_oe,
  output logic      [4:0]  pd_pu
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [5:0]  idx;
  logic        setup_rd;
  logic        acc_wr;
  logic [31:0] pin_raw;
  logic [31:0] pin_sync;
  logic [31:0] latch_all;
  logic [31:0] drv_all;
  logic [31:0] pu_all;
  logic [31:0] rd_all;
  logic [3:0]  hit_all;
  logic [31:0] out_all;
  logic [31:0] oe_all;
  logic [31:0] pupin_all;
  logic [7:0]  rd_sel;
  logic        hit;

  assign idx      = paddr[7:2];
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr   = psel & penable & pwrite;
  assign hit      = |hit_all;

  // Zero wait state: read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisation

  assign pin_raw = {3'h0, pd_in, pc_in, pb_in, pa_in};

  gpc_sync #(
    .W (32)
  ) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-port registers

  for (genvar p = 0; p < gpc_pkg::NPORT; p++) begin : g_port
    localparam logic [5:0] DATA_I = gpc_pkg::DATA_IDX[p];
    localparam logic [5:0] DRV_I  = gpc_pkg::IDX_DRV_BASE + 6'(p);
    localparam logic [5:0] PU_I   = gpc_pkg::IDX_PU_BASE + 6'(p);
    localparam logic [5:0] VIEW_I = gpc_pkg::IDX_VIEW_BASE + 6'(p);
    localparam logic [5:0] SET_I  = gpc_pkg::IDX_SET_BASE + 6'(p);
    localparam logic [5:0] CLR_I  = gpc_pkg::IDX_CLR_BASE + 6'(p);
    localparam logic [7:0] OMASK  = gpc_pkg::OUT_MASK[p];
    localparam logic [7:0] IMASK  = gpc_pkg::IN_MASK[p];

    logic [7:0] latch_q;
    logic [7:0] drv_q;
    logic [7:0] pu_q;
    logic [7:0] rd_d;

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        latch_q <= gpc_pkg::LATCH_RST[p]; // RULE12 RULE13 RULE14
      end else if (acc_wr && (idx == DATA_I || idx == VIEW_I)) begin
        latch_q <= pwdata[7:0] & OMASK; // RULE12 RULE13 RULE14
      end else if (acc_wr && idx == SET_I) begin
        // Modify starts from the latch, not the pins
        latch_q <= (latch_q | pwdata[7:0]) & OMASK; // RULE6
      end else if (acc_wr && idx == CLR_I) begin
        latch_q <= latch_q & ~pwdata[7:0]; // RULE6
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        drv_q <= gpc_pkg::DRV_RST;
      end else if (acc_wr && idx == DRV_I) begin
        drv_q <= pwdata[7:0] & OMASK; // RULE3
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        pu_q <= gpc_pkg::PU_RST;
      end else if (acc_wr && idx == PU_I) begin
        pu_q <= pwdata[7:0] & OMASK; // RULE7
      end
    end

    always_comb begin
      rd_d = 8'h00;
      if (idx == DATA_I) begin
        rd_d = pin_sync[p*8 +: 8] & IMASK; // RULE5
      end else if (idx == VIEW_I) begin
        rd_d = latch_q; // RULE4
      end else if (idx == DRV_I) begin
        rd_d = drv_q;
      end else if (idx == PU_I) begin
        rd_d = pu_q;
      end
    end

    assign hit_all[p] = (idx == DATA_I) | (idx == DRV_I) | (idx == PU_I) |
                        (idx == VIEW_I) | (idx == SET_I) | (idx == CLR_I);
    assign rd_all[p*8 +: 8]    = rd_d;
    assign latch_all[p*8 +: 8] = latch_q;
    assign drv_all[p*8 +: 8]   = drv_q;
    assign pu_all[p*8 +: 8]    = pu_q;
  end

  always_comb begin
    rd_sel = 8'h00;
    for (int p = 0; p < gpc_pkg::NPORT; p++) begin
      rd_sel = rd_sel | rd_all[p*8 +: 8];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= {24'h00_0000, rd_sel}; // RULE4 RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  for (genvar b = 0; b < 32; b++) begin : g_pin
    if (gpc_pkg::PIN_MASK[b]) begin : g_used
      gpc_pin_cell u_cell (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .latch      (latch_all[b]),
        .drv_sel    (drv_all[b]),
        .pu_sel     (pu_all[b]),
        .pseudo_ok  (gpc_pkg::PSEUDO_MASK[b]), // RULE2 RULE8
        .input_only (gpc_pkg::INONLY_MASK[b]), // RULE10 RULE11
        .pad_out    (out_all[b]),
        .pad_oe     (oe_all[b]),
        .pad_pu     (pupin_all[b])
      );
    end else begin : g_unused
      assign out_all[b]   = 1'b0;
      assign oe_all[b]    = 1'b0;
      assign pupin_all[b] = 1'b0;
    end
  end

  assign pa_out = out_all[7:0];
  assign pa_oe  = oe_all[7:0];
  assign pa_pu  = pupin_all[7:0];
  assign pb_out = out_all[15:8];
  assign pb_oe  = oe_all[15:8];
  assign pb_pu  = pupin_all[15:8];
  assign pc_out = out_all[23:16];
  assign pc_oe  = oe_all[23:16];
  assign pc_pu  = pupin_all[23:16];
  assign pd_out = out_all[28:24];
  assign pd_oe  = oe_all[28:24];
  assign pd_pu  = pupin_all[28:24];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_plain_read_pins: assert property ((setup_rd && idx == gpc_pkg::IDX_PB_DATA) |=>
      prdata == {24'h00_0000, $past(pin_sync[15:8])}) // RULE5
    else $error("port data read did not return pin levels");
  chk_view_read_latch: assert property ((setup_rd && idx == gpc_pkg::IDX_VIEW_BASE) |=>
      prdata == {24'h00_0000, $past(latch_all[7:0])}) // RULE4
    else $error("latch view read did not return the latch");
  chk_bit_set_merge: assert property ((acc_wr && idx == gpc_pkg::IDX_SET_BASE + 6'h1) |=>
      latch_all[15:8] == ($past(latch_all[15:8]) | $past(pwdata[7:0]))) // RULE6
    else $error("bit set did not merge into latch");
  chk_pa_write_mask: assert property ((acc_wr && idx == gpc_pkg::IDX_PA_DATA) |=>
      latch_all[7:0] == ($past(pwdata[7:0]) & 8'h7f)) // RULE12
    else $error("port A latch write wrong");
  chk_pc_write: assert property ((acc_wr && idx == gpc_pkg::IDX_PC_DATA) ##1
      !acc_wr |=> latch_all[23:16] == $past(pwdata[7:0], 2)) // RULE14
    else $error("port C latch write lost");
  chk_unmapped_error: assert property ((psel && penable && !hit) |-> pslverr)
    else $error("unmapped access not flagged");

  ////////////////////////////////////////////////////////////////////////////
  // Per-port read, write and mask checks

  chk_unmapped_read_zero: assert property ((setup_rd && !hit) |=> // RULE5
      prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  chk_pd_read_pins: assert property ((setup_rd && idx == gpc_pkg::IDX_PD_DATA) |=> // RULE8
      prdata == {27'h000_0000, $past(pin_sync[28:24])})
    else $error("port D read did not return pin levels");

  chk_pa_read_pins: assert property ((setup_rd && idx == gpc_pkg::IDX_PA_DATA) |=> // RULE5
      prdata == {24'h00_0000, $past(pin_sync[7:0])})
    else $error("port A read did not return pin levels");

  chk_pc_read_pins: assert property ((setup_rd && idx == gpc_pkg::IDX_PC_DATA) |=> // RULE5
      prdata == {24'h00_0000, $past(pin_sync[23:16])})
    else $error("port C read did not return pin levels");

  chk_pb_view_latch: assert property ((setup_rd && idx == gpc_pkg::IDX_VIEW_BASE + 6'h1) |=> // RULE4
      prdata == {24'h00_0000, $past(latch_all[15:8])})
    else $error("port B latch view wrong");

  chk_pc_view_latch: assert property ((setup_rd && idx == gpc_pkg::IDX_VIEW_BASE + 6'h2) |=> // RULE4
      prdata == {24'h00_0000, $past(latch_all[23:16])})
    else $error("port C latch view wrong");

  chk_bit_clear_drop: assert property ((acc_wr && idx == gpc_pkg::IDX_CLR_BASE + 6'h1) |=> // RULE6
      latch_all[15:8] == ($past(latch_all[15:8]) & ~$past(pwdata[7:0])))
    else $error("bit clear did not act on latch");

  chk_pb_write: assert property ((acc_wr && idx == gpc_pkg::IDX_PB_DATA) |=> // RULE13
      latch_all[15:8] == $past(pwdata[7:0]))
    else $error("port B latch write wrong");

  chk_pd_write_mask: assert property ((acc_wr && idx == gpc_pkg::IDX_PD_DATA) |=> // RULE8
      latch_all[31:24] == ($past(pwdata[7:0]) & 8'h1f))
    else $error("port D latch write wrong");

  chk_pa7_no_drive: assert property (!pa_oe[7]) // RULE10
    else $error("input-only pin enabled its driver");

  chk_pa_drive_mask: assert property ((acc_wr && idx == gpc_pkg::IDX_DRV_BASE) |=> // RULE3
      drv_all[7:0] == ($past(pwdata[7:0]) & 8'h7f))
    else $error("port A drive select write wrong");

  chk_pd_drive_write: assert property ((acc_wr && idx == gpc_pkg::IDX_DRV_BASE + 6'h3) |=> // RULE8
      drv_all[31:24] == ($past(pwdata[7:0]) & 8'h1f))
    else $error("port D drive select write wrong");

  chk_pb_pullup_write: assert property ((acc_wr && idx == gpc_pkg::IDX_PU_BASE + 6'h1) |=> // RULE7
      pu_all[15:8] == $past(pwdata[7:0]))
    else $error("port B pull-up write wrong");

  chk_pa_pullup_mask: assert property ((acc_wr && idx == gpc_pkg::IDX_PU_BASE) |=> // RULE7
      pu_all[7:0] == ($past(pwdata[7:0]) & 8'h7f))
    else $error("port A pull-up write wrong");

  chk_pa7_pullup_on: assert property ($past(nrst) |-> pa_pu[7]) // RULE11
    else $error("input-only pin lost its pull-up");

  chk_unmapped_no_write: assert property ((acc_wr && !hit) |=> // RULE12
      latch_all == $past(latch_all))
    else $error("unmapped write changed a latch");

endmodule : gpc_port_ctrl

`default_nettype wire

// ===== gpc_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/100ps
`default_nettype none

module gpc_sync #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : gpc_sync

`default_nettype wire

// ===== tb_gpio_port_pin_control.sv
// Self-checking bench for the port controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module tb_gpio_port_pin_control;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pa_out, pa_oe, pa_pu, pb_out, pb_oe, pb_pu, pc_out, pc_oe, pc_pu;
  logic [4:0]  pd_out, pd_oe, pd_pu;
  logic [28:0] lvl;
  logic [28:0] ext_en = '0;
  logic [28:0] ext_val = '0;
  logic [8:0]  exp_q[$];
  logic [8:0]  e;
  logic [31:0] seed = 32'h4fad;
  logic [31:0] r;
  int          error_cnt = 0;
  int          compares = 0;

  always #20 clk_sys = ~clk_sys;

  gpc_port_ctrl gpc_port_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pa_in(lvl[7:0]), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu),
    .pb_in(lvl[15:8]), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pu(pb_pu),
    .pc_in(lvl[23:16]), .pc_out(pc_out), .pc_oe(pc_oe), .pc_pu(pc_pu),
    .pd_in(lvl[28:24]), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pu(pd_pu)
  );

  gpc_board #(.W(29)) gpc_board_inst (
    .clk_sys(clk_sys), .oe({pd_oe, pc_oe, pb_oe, pa_oe}),
    .out({pd_out, pc_out, pb_out, pa_out}), .pu({pd_pu, pc_pu, pb_pu, pa_pu}),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(lvl)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     input logic [8:0] ex);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back(ex);
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Read results are judged against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      `CHK({pslverr, prdata}, {e[8], 24'h0, e[7:0]})
    end
  end

  initial begin
    #(40 * 5000);
    error_cnt++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    settle();
    `CHK(pa_oe, 8'h00)
    `CHK(pa_pu[7], 1'b1)
    apb(1'b0, 6'h28, 8'h00, 9'h07f);
    apb(1'b0, 6'h29, 8'h00, 9'h0ff);
    apb(1'b0, 6'h2a, 8'h00, 9'h0ff);
    apb(1'b0, 6'h3f, 8'h00, 9'h100);
    apb(1'b1, gpc_pkg::IDX_PA_DATA, 8'hff, 9'h0);
    apb(1'b0, 6'h28, 8'h00, 9'h07f);
    apb(1'b1, 6'h31, 8'h0f, 9'h0);
    apb(1'b0, 6'h29, 8'h00, 9'h0f0);
    apb(1'b1, 6'h2d, 8'h01, 9'h0);
    apb(1'b0, 6'h29, 8'h00, 9'h0f1);
    apb(1'b0, 6'h2d, 8'h00, 9'h000);
    apb(1'b1, 6'h20, 8'hff, 9'h0);
    settle();
    `CHK(pa_oe, 8'h7f)
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      r = seed;
      apb(1'b1, gpc_pkg::IDX_PB_DATA, r[7:0], 9'h0);
      apb(1'b1, 6'h21, 8'hff, 9'h0);
      settle();
      `CHK(pb_oe, 8'hff)
      `CHK(pb_out, r[7:0])
      apb(1'b1, 6'h21, 8'h00, 9'h0);
      settle();
      `CHK(pb_oe, ~r[7:0])
      `CHK(pb_out & ~r[7:0], 8'h00)
      apb(1'b1, 6'h25, r[15:8], 9'h0);
      settle();
      `CHK(pb_pu, r[15:8])
    end
    apb(1'b1, 6'h24, 8'h00, 9'h0);
    settle();
    `CHK(pa_pu, 8'h80)
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      ext_en[23:16] <= 8'hff;
      ext_val[23:16] <= seed[7:0];
      settle();
      settle();
      `CHK(pc_oe, 8'h00)
      apb(1'b0, gpc_pkg::IDX_PC_DATA, 8'h00, {1'b0, seed[7:0]});
      apb(1'b0, 6'h2a, 8'h00, 9'h0ff);
    end
    apb(1'b1, gpc_pkg::IDX_PC_DATA, 8'h5a, 9'h0);
    apb(1'b0, 6'h2a, 8'h00, 9'h05a);
    apb(1'b1, gpc_pkg::IDX_PD_DATA, 8'hea, 9'h0);
    apb(1'b1, 6'h23, 8'hff, 9'h0);
    settle();
    `CHK(pd_oe, 5'h1f)
    `CHK(pd_out, 5'h0a)
    apb(1'b0, gpc_pkg::IDX_PD_DATA, 8'h00, 9'h00a);
    // Pseudo pins kick high briefly, plain pins release at once
    apb(1'b1, 6'h20, 8'h00, 9'h0);
    apb(1'b1, gpc_pkg::IDX_PA_DATA, 8'h00, 9'h0);
    settle();
    `CHK(pa_oe, 8'h7f)
    apb(1'b1, gpc_pkg::IDX_PA_DATA, 8'h0f, 9'h0);
    @(posedge clk_sys);
    #1;
    `CHK(pa_oe[3:0], 4'h7)
    `CHK(pa_out[2:0], 3'h7)
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(pa_oe[3:0], 4'h0)
    settle();
    close_out();
  end
endmodule : tb_gpio_port_pin_control
`default_nettype wire
